// File: inc/elr_pkg.sv
// Purpose: Shared constants of the extended log read engine.
// Assumes: Byte offsets of a 32-bit AXI4-Lite register map.
// Notes:   Log sectors are 512 bytes, delivered as 128 little-endian words.
`default_nettype none
package elr_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_SECTOR_COUNT = 8'h00;
  localparam logic [7:0] OFS_LOG_ADDRESS  = 8'h04;
  localparam logic [7:0] OFS_FIRST_SECTOR = 8'h08;
  localparam logic [7:0] OFS_COMMAND      = 8'h0C;
  localparam logic [7:0] OFS_ERROR        = 8'h10;
  localparam logic [7:0] OFS_DATA         = 8'h14;
  localparam logic [7:0] OFS_FEATURE      = 8'h18;
  localparam logic [7:0] OFS_ERROR_COUNT  = 8'h1C;
  // Command code and log addresses.
  localparam logic [7:0] CMD_READ_LOG_EXT    = 8'h2F;
  localparam logic [7:0] LOG_DIRECTORY       = 8'h00;
  localparam logic [7:0] LOG_ERROR_EXT       = 8'h03;
  localparam logic [7:0] LOG_SELF_TEST_BASIC = 8'h06;
  localparam logic [7:0] LOG_SELF_TEST_EXT   = 8'h07;
  localparam logic [7:0] LOG_POWER           = 8'h08;
  localparam logic [7:0] LOG_CMD_ERROR       = 8'h10;
  localparam logic [7:0] LOG_PHY_EVENTS      = 8'h11;
  localparam logic [7:0] LOG_STREAM_PERF     = 8'h20;
  localparam logic [7:0] LOG_WRITE_STREAM    = 8'h21;
  localparam logic [7:0] LOG_READ_STREAM     = 8'h22;
  localparam logic [7:0] VENDOR_FIRST        = 8'h80;
  localparam logic [7:0] VENDOR_LAST         = 8'h9F;
  // Log lengths in sectors and header values.
  localparam logic [15:0] SINGLE_SECTOR      = 16'h0001;
  localparam logic [15:0] VENDOR_SECTORS     = 16'h0010;
  localparam logic [15:0] DIR_VERSION        = 16'h0001;
  localparam logic [7:0]  ERR_LOG_VERSION    = 8'h01;
  localparam logic [7:0]  SELF_TEST_REVISION = 8'h01;
  // Sector and error entry layout, in words.
  localparam logic [6:0]  SECTOR_LAST_WORD = 7'h7F;
  localparam logic [6:0]  ERR_COUNT_WORD   = 7'h7D;
  localparam logic [6:0]  ENTRY_FIRST_WORD = 7'h01;
  localparam logic [6:0]  ENTRY_LAST_WORD  = 7'h7C;
  localparam logic [6:0]  ENTRY_WORDS      = 7'h1F;
  localparam logic [4:0]  REC_LAST_WORD    = 5'h1E;
  localparam logic [2:0]  INDEX_MAX        = 3'h4;
  localparam int          ENTRY_DEPTH      = 124;
  // Error and status bit positions.
  localparam int ERR_UNC = 6;
  localparam int ERR_IDN = 4;
  localparam int ERR_ABT = 2;
  localparam logic [7:0] ERR_FIXED_ZERO = 8'hAB;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF  = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_COR = 2;
  localparam int ST_ERR = 0;
  // Reset values and bus answers.
  localparam logic [7:0] TASKFILE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_DECERR    = 2'h3;
endpackage
`default_nettype wire

// File: hdl/err_entry_ram.sv
// Purpose: Word store for the four error log entries.
// Assumes: One write port and one read port on the same clock.
// Notes:   Contents are not cleared; the reader masks entries never filled.
`timescale 1ns/1ps
`default_nettype none
module err_entry_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 124,
  parameter int AW    = 7
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             writeEn,
  input  wire logic [AW-1:0]    writeAddr,
  input  wire logic [WIDTH-1:0] writeData,
  input  wire logic [AW-1:0]    readAddr,
  output logic      [WIDTH-1:0] readData
);
  logic [WIDTH-1:0] store [DEPTH];

  // Write port; addresses past the depth are dropped.
  always_ff @(posedge clock)
  begin
    if (writeEn && (int'(writeAddr) < DEPTH))
    begin
      store[writeAddr] <= writeData;
    end
  end

  // Registered read, one cycle after the address.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readData <= '0;
    end
    else if (int'(readAddr) < DEPTH)
    begin
      readData <= store[readAddr];
    end
    else
    begin
      readData <= '0;
    end
  end
endmodule // err_entry_ram
`default_nettype wire

// File: hdl/extended_log_read_engine.sv
// Purpose: Device side of the extended log read command behind AXI4-Lite.
// Assumes: Host writes task-file bytes, then the command; reads DATA words.
// Notes:   Each sector is 128 words; the host interrupt pulses per block.
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Command 2Fh returns requested log sectors
// R2 - Interrupt once per data block transferred
// R3 - Host gives 16-bit count, low then high; the code takes the first byte written as the high byte
// R4 - Host gives 16-bit first sector offset
// R5 - Transfer starts at offset, whatever count
// R6 - Supported logs listed; vendor logs 80h-9Fh
// R7 - Log 06h always aborts
// R8 - Abort unsupported, disabled or invalid requests
// R9 - Extended self-test log holds both entry kinds
// R10 - Directory version word reads 0001h
// R11 - Directory length of log N at 2N
// R12 - Vendor logs report sixteen sectors
// R13 - Faulty commands never enter error log
// R14 - Error sector layout: header, entries, count, checksum
// R15 - Error log version reads 01h
// R16 - Index names newest entry, zero to four
// R17 - Error bits 6,4,2 valid, others zero
// R18 - Completion status clears busy, fault, corrected
// R19 - Four entries form a ring
// R20 - Unfilled entries read as zeros
// R21 - Device error count saturates
// R22 - Checksum makes sector byte sum zero
// R23 - Abort when request passes log end
module extended_log_read_engine (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        smartEnable,
  input  wire logic        errEvent,
  input  wire logic [31:0] errInfo,
  output logic             hostIrq
);
  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    FETCH = 2'b01,
    LOAD  = 2'b11,
    READY = 2'b10
  } phase_e;

  typedef struct packed {
    phase_e      phase;
    logic [7:0]  countCur;
    logic [7:0]  countPrev;
    logic [7:0]  offCur;
    logic [7:0]  offPrev;
    logic [7:0]  logAddr;
    logic [7:0]  feature;
    logic [7:0]  logSel;
    logic [15:0] sector;
    logic [15:0] remaining;
    logic [6:0]  wordIdx;
    logic [7:0]  byteSum;
    logic [31:0] dataWord;
    logic        data_request;
    logic [7:0]  errFlags;
    logic        blockIrq;
    logic        recording;
    logic [4:0]  recWord;
    logic [31:0] recInfo;
    logic [1:0]  slot;
    logic [3:0]  filled;
    logic [2:0]  errIndex;
    logic [15:0] errCount;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_s;

  state_s      r;
  state_s      next_r;
  logic        wrFire;
  logic        rdFire;
  logic        arOpen;
  logic        cmdWrite;
  logic        cmdBad;
  logic        gated;
  logic [15:0] reqCount;
  logic [15:0] reqOffset;
  logic [15:0] reqLen;
  logic [16:0] reqEnd;
  logic [7:0]  statusByte;
  logic [31:0] memData;
  logic [6:0]  memWrAddr;
  logic [31:0] memWrData;
  logic [6:0]  memRdAddr;
  logic [1:0]  entrySel;

  // Sectors held by each log; zero means no such log.
  function automatic logic [15:0] logLength(input logic [7:0] a);
    logic [15:0] len;
    len = 16'h0000;
    case (a)
      elr_pkg::LOG_DIRECTORY, elr_pkg::LOG_ERROR_EXT, elr_pkg::LOG_SELF_TEST_EXT,
      elr_pkg::LOG_POWER, elr_pkg::LOG_CMD_ERROR, elr_pkg::LOG_PHY_EVENTS,
      elr_pkg::LOG_STREAM_PERF, elr_pkg::LOG_WRITE_STREAM, elr_pkg::LOG_READ_STREAM:
        len = elr_pkg::SINGLE_SECTOR; // R6
      default:
      begin
        if (a >= elr_pkg::VENDOR_FIRST && a <= elr_pkg::VENDOR_LAST)
        begin
          len = elr_pkg::VENDOR_SECTORS; // R12
        end
      end
    endcase
    return len;
  endfunction

  // The count and offset each join a history byte and the current byte of the task file.
  assign reqCount  = {r.countPrev, r.countCur}; // R3
  assign reqOffset = {r.offPrev, r.offCur}; // R4
  assign reqLen    = logLength(r.logAddr);
  assign reqEnd    = {1'b0, reqOffset} + {1'b0, reqCount};
  assign gated     = (r.logAddr == elr_pkg::LOG_ERROR_EXT)
                  || (r.logAddr == elr_pkg::LOG_SELF_TEST_EXT)
                  || (r.logAddr >= elr_pkg::VENDOR_FIRST && r.logAddr <= elr_pkg::VENDOR_LAST);

  // Any failed check aborts before a single word moves.
  assign cmdBad = (s_axi_wdata[7:0] != elr_pkg::CMD_READ_LOG_EXT) // R1
               || (r.logAddr == elr_pkg::LOG_SELF_TEST_BASIC) // R7
               || (reqLen == 16'h0000) || (gated && !smartEnable) // R8
               || (reqCount == 16'h0000)
               || (reqEnd > {1'b0, reqLen}); // R23

  // Bus handshakes; data reads stall only during the two-cycle word fetch.
  assign wrFire        = s_axi_awvalid && s_axi_wvalid && !r.bvalid;
  assign s_axi_awready = wrFire;
  assign s_axi_wready  = wrFire;
  assign arOpen        = !r.rvalid && (r.phase == IDLE || r.phase == READY);
  assign s_axi_arready = arOpen;
  assign rdFire        = s_axi_arvalid && arOpen;
  assign cmdWrite      = wrFire && (s_axi_awaddr == elr_pkg::OFS_COMMAND)
                      && s_axi_wstrb[0] && (r.phase == IDLE);

  // Busy while fetching a block, data request while it can be read.
  assign statusByte = {(r.phase != IDLE) && !r.data_request, 1'b1, 1'b0, 1'b1,
                       r.data_request, 1'b0, 1'b0, r.errFlags[elr_pkg::ERR_ABT]}; // R18

  // Entry storage: the recorder writes, the sector builder reads.
  assign memWrAddr = 7'(r.slot) * elr_pkg::ENTRY_WORDS + 7'(r.recWord);
  assign memWrData = (r.recWord == 5'h00) ? r.recInfo : 32'h0000_0000;
  assign memRdAddr = r.wordIdx - elr_pkg::ENTRY_FIRST_WORD;
  assign entrySel  = 2'(memRdAddr / elr_pkg::ENTRY_WORDS);

  err_entry_ram #(
    .WIDTH (32),
    .DEPTH (elr_pkg::ENTRY_DEPTH),
    .AW    (7)
  ) entries (
    .clock     (clock),
    .rst_n     (rst_n),
    .writeEn   (r.recording),
    .writeAddr (memWrAddr),
    .writeData (memWrData),
    .readAddr  (memRdAddr),
    .readData  (memData)
  );

  // Next-state logic for bus, command sequencer and error recorder.
  always_comb
  begin
    logic [31:0] word;
    logic [7:0]  pair;
    next_r          = r;
    word            = 32'h0000_0000;
    pair            = {r.wordIdx, 1'b0};
    next_r.blockIrq = 1'b0;
    if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
    end
    // Register writes; count and offset bytes push the old byte into history.
    if (wrFire)
    begin
      next_r.bvalid = 1'b1;
      next_r.bresp  = elr_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        elr_pkg::OFS_SECTOR_COUNT:
        begin
          if (s_axi_wstrb[0] && r.phase == IDLE)
          begin
            next_r.countPrev = r.countCur; // R3
            next_r.countCur  = s_axi_wdata[7:0];
          end
        end
        elr_pkg::OFS_FIRST_SECTOR:
        begin
          if (s_axi_wstrb[0] && r.phase == IDLE)
          begin
            next_r.offPrev = r.offCur; // R4
            next_r.offCur  = s_axi_wdata[7:0];
          end
        end
        elr_pkg::OFS_LOG_ADDRESS:
        begin
          if (s_axi_wstrb[0] && r.phase == IDLE)
          begin
            next_r.logAddr = s_axi_wdata[7:0];
          end
        end
        elr_pkg::OFS_FEATURE:
        begin
          if (s_axi_wstrb[0] && r.phase == IDLE)
          begin
            next_r.feature = s_axi_wdata[7:0];
          end
        end
        elr_pkg::OFS_COMMAND, elr_pkg::OFS_ERROR, elr_pkg::OFS_DATA,
        elr_pkg::OFS_ERROR_COUNT:
        begin
          next_r.bresp = elr_pkg::RESP_OKAY;
        end
        default: next_r.bresp = elr_pkg::RESP_DECERR;
      endcase
    end
    // A command write either aborts at once or opens the first sector.
    if (cmdWrite)
    begin
      next_r.errFlags = 8'h00; // R17
      if (cmdBad)
      begin
        // Aborts leave the error log and its count alone.
        next_r.errFlags[elr_pkg::ERR_ABT] = 1'b1; // R13
        next_r.blockIrq = 1'b1;
      end
      else
      begin
        next_r.phase     = FETCH; // R1
        next_r.logSel    = r.logAddr;
        next_r.sector    = reqOffset; // R5
        next_r.remaining = reqCount;
        next_r.wordIdx   = 7'h00;
        next_r.byteSum   = 8'h00;
      end
    end
    // Register reads.
    if (rdFire)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = elr_pkg::RESP_OKAY;
      case (s_axi_araddr)
        elr_pkg::OFS_SECTOR_COUNT: next_r.rdata = {16'h0000, r.countPrev, r.countCur};
        elr_pkg::OFS_LOG_ADDRESS:  next_r.rdata = {24'h00_0000, r.logAddr};
        elr_pkg::OFS_FIRST_SECTOR: next_r.rdata = {16'h0000, r.offPrev, r.offCur};
        elr_pkg::OFS_COMMAND:      next_r.rdata = {24'h00_0000, statusByte};
        elr_pkg::OFS_ERROR:        next_r.rdata = {24'h00_0000, r.errFlags};
        elr_pkg::OFS_DATA:         next_r.rdata = (r.phase == READY) ? r.dataWord : 32'h0;
        elr_pkg::OFS_FEATURE:      next_r.rdata = {24'h00_0000, r.feature};
        elr_pkg::OFS_ERROR_COUNT:  next_r.rdata = {13'h0000, r.errIndex, r.errCount};
        default:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = elr_pkg::RESP_DECERR;
        end
      endcase
    end
    // Sector builder: fetch, assemble one word, wait for the host to take it.
    case (r.phase)
      IDLE: next_r.phase = next_r.phase;
      FETCH: next_r.phase = LOAD;
      LOAD:
      begin
        case (r.logSel)
          elr_pkg::LOG_DIRECTORY:
          begin
            word[31:16] = logLength(8'(pair + 8'h01)); // R11
            word[15:0]  = (r.wordIdx == 7'h00) ? elr_pkg::DIR_VERSION : logLength(pair); // R10
          end
          elr_pkg::LOG_ERROR_EXT:
          begin
            if (r.wordIdx == 7'h00)
            begin
              word = {13'h0000, r.errIndex, 8'h00, elr_pkg::ERR_LOG_VERSION}; // R15
            end
            else if (r.wordIdx <= elr_pkg::ENTRY_LAST_WORD)
            begin
              word = r.filled[entrySel] ? memData : 32'h0000_0000; // R20
            end
            else if (r.wordIdx == elr_pkg::ERR_COUNT_WORD)
            begin
              word = {16'h0000, r.errCount}; // R14
            end
          end
          elr_pkg::LOG_SELF_TEST_EXT:
          begin
            // No self-test has run here, so the ring of mixed entries is empty.
            if (r.wordIdx == 7'h00)
            begin
              word = {24'h00_0000, elr_pkg::SELF_TEST_REVISION}; // R9
            end
          end
          default: word = 32'h0000_0000;
        endcase
        if (r.wordIdx == elr_pkg::SECTOR_LAST_WORD && r.logSel != elr_pkg::LOG_DIRECTORY)
        begin
          word[31:24] = 8'h00 - r.byteSum; // R22
        end
        next_r.byteSum  = r.byteSum + word[7:0] + word[15:8] + word[23:16] + word[31:24];
        next_r.dataWord = word;
        next_r.phase    = READY;
        if (r.wordIdx == 7'h00)
        begin
          next_r.data_request      = 1'b1;
          next_r.blockIrq = 1'b1; // R2
        end
      end
      READY:
      begin
        if (rdFire && s_axi_araddr == elr_pkg::OFS_DATA)
        begin
          next_r.wordIdx = r.wordIdx + 7'h01;
          next_r.phase   = FETCH;
          if (r.wordIdx == elr_pkg::SECTOR_LAST_WORD)
          begin
            next_r.data_request       = 1'b0;
            next_r.byteSum   = 8'h00;
            next_r.sector    = r.sector + 16'h0001;
            next_r.remaining = r.remaining - 16'h0001;
            if (r.remaining == 16'h0001)
            begin
              next_r.phase = IDLE; // R18
            end
          end
        end
      end
      default: next_r.phase = IDLE;
    endcase
    // Recorder: one logged error rewrites a whole entry, 31 words.
    if (r.recording)
    begin
      next_r.recWord = r.recWord + 5'h01;
      if (r.recWord == elr_pkg::REC_LAST_WORD)
      begin
        next_r.recording      = 1'b0;
        next_r.filled[r.slot] = 1'b1;
        next_r.errIndex       = 3'({1'b0, r.slot}) + 3'h1; // R16
        next_r.slot           = r.slot + 2'h1; // R19
        if (r.errCount != 16'hFFFF)
        begin
          next_r.errCount = r.errCount + 16'h0001; // R21
        end
      end
    end
    else if (errEvent)
    begin
      next_r.recording = 1'b1;
      next_r.recWord   = 5'h00;
      next_r.recInfo   = errInfo;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r          <= '0;
      r.phase    <= IDLE;
      r.countCur <= elr_pkg::TASKFILE_RESET;
      r.offCur   <= elr_pkg::TASKFILE_RESET;
      r.logAddr  <= elr_pkg::TASKFILE_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp  = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp  = r.rresp;
  assign s_axi_rdata  = r.rdata;
  assign hostIrq      = r.blockIrq;

  // Checks on the sequencer, the sector content and the error log.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_abort_log06: assert property ( // R7
    cmdWrite && r.logAddr == elr_pkg::LOG_SELF_TEST_BASIC
    |=> r.errFlags[elr_pkg::ERR_ABT] && r.phase == IDLE && hostIrq)
    else $error("Log 06h request did not abort.");
  a_abort_overrun: assert property ( // R23
    cmdWrite && reqEnd > {1'b0, reqLen} |=> r.errFlags[elr_pkg::ERR_ABT] && !r.data_request)
    else $error("Request past log end was not aborted.");
  a_start_offset: assert property ( // R5
    cmdWrite && !cmdBad |=> r.phase == FETCH && r.sector == $past(reqOffset) ##2 hostIrq)
    else $error("Transfer did not start at the offset.");
  a_irq_block: assert property ( // R2
    hostIrq |-> (r.phase == READY && r.wordIdx == 7'h00 && r.data_request)
             || r.errFlags[elr_pkg::ERR_ABT])
    else $error("Interrupt without a data block.");
  a_error_bits: assert property ( // R17
    (r.errFlags & elr_pkg::ERR_FIXED_ZERO) == 8'h00)
    else $error("Error bits that must be zero are set.");
  a_done_status: assert property ( // R18
    $fell(r.data_request) && r.phase == IDLE
    |-> !statusByte[elr_pkg::ST_BSY] && !statusByte[elr_pkg::ST_DF]
        && !statusByte[elr_pkg::ST_COR] && statusByte[elr_pkg::ST_RDY])
    else $error("Completion status is wrong.");
  a_dir_version: assert property ( // R10
    r.phase == LOAD && r.logSel == elr_pkg::LOG_DIRECTORY && r.wordIdx == 7'h00
    |=> r.dataWord[15:0] == elr_pkg::DIR_VERSION)
    else $error("Directory version word is wrong.");
  a_vendor_len: assert property ( // R12
    r.phase == LOAD && r.logSel == elr_pkg::LOG_DIRECTORY && r.wordIdx == 7'h40
    |=> r.dataWord == {elr_pkg::VENDOR_SECTORS, elr_pkg::VENDOR_SECTORS})
    else $error("Vendor log length is not sixteen.");
  a_err_header: assert property ( // R15
    r.phase == LOAD && r.logSel == elr_pkg::LOG_ERROR_EXT && r.wordIdx == 7'h00
    |=> r.dataWord[7:0] == elr_pkg::ERR_LOG_VERSION && r.dataWord[31:16] <= 16'h0004)
    else $error("Error log header is wrong.");
  a_sector_sum: assert property ( // R22
    r.phase == READY && r.wordIdx == elr_pkg::SECTOR_LAST_WORD
    && r.logSel != elr_pkg::LOG_DIRECTORY |-> r.byteSum == 8'h00)
    else $error("Sector bytes do not sum to zero.");
  a_ring_wrap: assert property ( // R19
    r.recording && r.recWord == elr_pkg::REC_LAST_WORD && r.slot == 2'h3
    |=> r.slot == 2'h0 && r.errIndex == elr_pkg::INDEX_MAX)
    else $error("Entry ring did not wrap.");
  a_count_hold: assert property ( // R21
    r.errCount == 16'hFFFF |=> r.errCount == 16'hFFFF)
    else $error("Error count wrapped.");
  a_abort_unlogged: assert property ( // R13
    cmdWrite && cmdBad && !r.recording && !errEvent |=> !r.recording)
    else $error("Aborted command reached the error log.");

  c_abort: cover property (cmdWrite && cmdBad);
  c_block: cover property (hostIrq && r.data_request);
  c_done: cover property ($fell(r.data_request) && r.phase == IDLE);
  c_record: cover property (r.recording && r.recWord == elr_pkg::REC_LAST_WORD);
endmodule // extended_log_read_engine
`default_nettype wire

// File: sim/host_model.sv
// Purpose: Host that issues AXI4-Lite register cycles to the log engine.
// Assumes: The engine answers each channel with its own ready or valid.
// Notes:   A wait of 200 cycles is a hang and ends the run as failed.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clock,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // The bus starts idle with every valid and ready low and all write strobes set.
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // Waits for one handshake; k picks the channel.
  task automatic waitFor(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (!(k == 0 ? s_axi_awready && s_axi_wready : k == 1 ? s_axi_bvalid
             : k == 2 ? s_axi_arready : s_axi_rvalid) && n < 200);
    if (n >= 200)
      tb_extended_log_read_engine.hang();
  endtask
  // Write cycle; released data shows the inverse so stale values never match.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    waitFor(0);
    s_axi_bready  <= 1'b1;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_wdata   <= ~d;
    waitFor(1);
    r = s_axi_bresp;
    s_axi_bready  <= 1'b0;
  endtask
  // Read cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    waitFor(2);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    waitFor(3);
    d = s_axi_rdata;
    s_axi_rready  <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// File: sim/tb_extended_log_read_engine.sv
// Purpose: Self-checking bench of the extended log read engine.
// Assumes: Host cycles come from host_model; expectations from the rules.
// Notes:   Device error count saturation is too long to reach here.
`timescale 1ns/1ps
`default_nettype none
module tb_extended_log_read_engine;
  logic clock, rst_n, smartEnable, errEvent, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, hostIrq;
  logic [1:0] s_axi_bresp, r;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, errInfo, w, sec [128];
  int n_fail, n_tests, nIrq, sum;
  int di[10] = '{0, 1, 3, 4, 8, 16, 17, 64, 79, 80};
  logic [31:0] de[10] = '{1, 32'h10000, 32'h10000, 1, 32'h10001, 32'h10001, 1,
                          32'h100010, 32'h100010, 0};
  int ei[7] = '{0, 1, 2, 32, 63, 94, 125};
  logic [31:0] ee[7] = '{32'h10001, 32'h104, 0, 32'h101, 32'h102, 32'h103, 5};
  logic [7:0] al[6] = '{8'h06, 8'h05, 8'h03, 8'h00, 8'h9F, 8'h00};
  logic [7:0] ac[6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h02, 8'h01};
  logic [7:0] ao[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00};
  logic [7:0] oc[6] = '{8'h2F, 8'h2F, 8'h2F, 8'h2F, 8'h2F, 8'h20};
  extended_log_read_engine uut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready, .smartEnable, .errEvent,
    .errInfo, .hostIrq);
  host_model host (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready);
  // Free-running 200 MHz clock and a count of interrupt pulses.
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
    if (hostIrq === 1'b1)
      nIrq++;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    final_report();
  endtask
  task automatic wb(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, {24'h0, d}, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask
  task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] e);
    host.rd(a, w);
    chk(nm, e, w);
  endtask
  // Count and offset go high byte first, so the history byte holds the top half.
  task automatic issue(input logic [7:0] lg, input logic [7:0] cnt, input logic [7:0] ofs,
                       input logic [7:0] cmd);
    wb(elr_pkg::OFS_SECTOR_COUNT, 8'h00);
    wb(elr_pkg::OFS_SECTOR_COUNT, cnt);
    wb(elr_pkg::OFS_FIRST_SECTOR, 8'h00);
    wb(elr_pkg::OFS_FIRST_SECTOR, ofs);
    wb(elr_pkg::OFS_LOG_ADDRESS, lg);
    wb(elr_pkg::OFS_COMMAND, cmd);
  endtask
  task automatic rdsec();
    sum = 0;
    for (int i = 0; i < 128; i++)
    begin
      host.rd(elr_pkg::OFS_DATA, sec[i]);
      sum += sec[i][7:0] + sec[i][15:8] + sec[i][23:16] + sec[i][31:24];
    end
  endtask
  // Main sequence: directory, vendor boundary, aborts, error log.
  initial
  begin
    {n_fail, n_tests, nIrq} = '0;
    {rst_n, errEvent, errInfo} = '0;
    smartEnable = 1'b1;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    issue(elr_pkg::LOG_DIRECTORY, 8'h01, 8'h00, elr_pkg::CMD_READ_LOG_EXT);
    rdsec();
    foreach (di[k]) chk("dir word", de[k], sec[di[k]]);
    rreg("status", elr_pkg::OFS_COMMAND, 32'h50);
    rreg("error", elr_pkg::OFS_ERROR, 32'h0);
    issue(8'h80, 8'h01, 8'h0F, elr_pkg::CMD_READ_LOG_EXT);
    rdsec();
    rreg("vendor status", elr_pkg::OFS_COMMAND, 32'h50);
    issue(elr_pkg::LOG_SELF_TEST_EXT, 8'h01, 8'h00, 8'h2F);
    rdsec();
    chk("self-test", 32'h1, sec[0]);
    for (int k = 0; k < 6; k++)
    begin
      smartEnable <= (k != 2);
      issue(al[k], ac[k], ao[k], oc[k]);
      rreg("abort status", elr_pkg::OFS_COMMAND, 32'h51);
      rreg("abort error", elr_pkg::OFS_ERROR, 32'h04);
    end
    smartEnable <= 1'b1;
    rreg("count", elr_pkg::OFS_ERROR_COUNT, 32'h0);
    issue(elr_pkg::LOG_ERROR_EXT, 8'h01, 8'h00, elr_pkg::CMD_READ_LOG_EXT);
    rdsec();
    chk("empty entry", 32'h0, sec[40]);
    repeat (2) @(posedge clock);
    chk("irq count", 32'd10, 32'(nIrq));
    // Recording takes 31 cycles, so 40 spaces the events safely.
    for (int k = 0; k < 5; k++)
    begin
      errInfo  <= 32'h100 + 32'(k);
      errEvent <= 1'b1;
      @(posedge clock);
      errEvent <= 1'b0;
      repeat (40) @(posedge clock);
    end
    rreg("count", elr_pkg::OFS_ERROR_COUNT, 32'h0001_0005);
    issue(elr_pkg::LOG_ERROR_EXT, 8'h01, 8'h00, elr_pkg::CMD_READ_LOG_EXT);
    rdsec();
    foreach (ei[k]) chk("err word", ee[k], sec[ei[k]]);
    chk("checksum", 32'h0, 32'(sum % 256));
    final_report();
  end
endmodule // tb_extended_log_read_engine
`default_nettype wire
